// >>> tb/otdfc_asserts.sv
// Checker: register bus handshakes and light output relations
`timescale 1ns/1ps
`default_nettype none
module otdfc_asserts
  import otdfc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic led_on,
  input wire otdfc_amp_t color_amp,
  input wire logic frame_active
);
  logic [9:0] amp_sum;
  assign amp_sum = 10'(color_amp.src0) + 10'(color_amp.src1) + 10'(color_amp.src2);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Full FIFO may hold a data push, so that address is left out
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr != ADDR_TXDATA;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_answer_a: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read data late");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rst_dark_a: assert property ($rose(aresetn) |-> !frame_active && !led_on && color_amp == '0)
    else $error("light active after reset");
  color_dark_a: assert property (color_amp != '0 |-> !led_on)
    else $error("plain light on during colour drive");
  color_sum_a: assert property ($past(frame_active, 2) && frame_active &&
    amp_sum != 0 && $past(amp_sum) != 0 |-> amp_sum == $past(amp_sum))
    else $error("colour power sum moved within frame");
endmodule // otdfc_asserts
bind otdfc_top otdfc_asserts u_asserts (.*);
`default_nettype wire

// >>> tb/otdfc_bench.sv
// Bench: register tests and light output checks per mode
`timescale 1ns/1ps
`default_nettype none
module otdfc_bench;
  import otdfc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rdv;
  logic led_on, frame_active, full;
  otdfc_amp_t color_amp;
  logic rx_clr = 1'b0;
  logic [4:0] win_on;
  logic [15:0] frm_on_q, frm_len_q;
  logic [9:0] amp_sum;
  int errors = 0, compares = 0, cycles = 0, wait_n;
  localparam logic [7:0] RA [6] = '{ADDR_CTRL, ADDR_DIM, ADDR_SUBF, ADDR_COMP, ADDR_DIV, ADDR_STATUS};
  localparam logic [31:0] RV [6] = '{32'(CTRL_RST), 32'(DIM_RST), 32'(SUBF_RST), 32'(COMP_RST),
    32'(DIV_RST), {8'h0, DIM_RST, 16'h0}};
  localparam logic [7:0] DT [4] = '{8'h00, 8'h40, 8'hc0, 8'hff};

  otdfc_top #(.MAX_FLICKER_PERIOD_NS(4000)) dut (.*);
  otdfc_rx_model rx (.*);

  always #20 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    compares++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      errors++;
      $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    wait_n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      aw_done = aw_done | (s_axi_awready === 1'b1);
      w_done = w_done | (s_axi_wready === 1'b1);
      if (aw_done) s_axi_awvalid <= 1'b0;
      if (w_done) s_axi_wvalid <= 1'b0;
    end
    do begin
      @(posedge aclk);
      wait_n++;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rdv = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  task automatic start_frame(input logic [31:0] ctrl, input logic [31:0] dim,
    input logic [31:0] comp, input int n);
    wr(ADDR_CTRL, ctrl);
    wr(ADDR_DIM, dim);
    wr(ADDR_COMP, comp);
    repeat (40) @(posedge aclk);
    rx_clr <= 1'b1;
    @(posedge aclk);
    rx_clr <= 1'b0;
    for (int i = 0; i < n; i++)
      wr(ADDR_TXDATA, {23'h0, i == n - 1, 8'ha5 ^ 8'(i)});
  endtask
  task automatic end_frame();
    while (frame_active !== 1'b1) @(posedge aclk);
    while (frame_active !== 1'b0) @(posedge aclk);
  endtask
  task automatic frame(input logic [31:0] ctrl, input logic [31:0] dim, input logic [31:0] comp,
    input int n, input int on, input int len);
    start_frame(ctrl, dim, comp, n);
    end_frame();
    chk(32'(frm_len_q), len);
    rng(32'(frm_on_q), (on > 0) ? on - 1 : 0, on + 1);
  endtask

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (RA[i]) begin
      rd(RA[i]);
      chk(rdv, RV[i]);
    end
    rd(ADDR_TXDATA);
    chk(rdv, 32'h0);
    chk(32'(resp), 32'(RESP_OKAY));
    $display("test reset_values done");
    wr(8'h1c, 32'hffff_ffff);
    chk(32'(resp), 32'(RESP_SLVERR));
    rd(8'h1c);
    chk(rdv, 32'h0);
    chk(32'(resp), 32'(RESP_SLVERR));
    $display("test unmapped done");
    wr(ADDR_DIV, 32'h0);
    foreach (DT[i]) begin
      wr(ADDR_DIM, 32'(DT[i]));
      repeat (40) @(posedge aclk);
      chk(32'(win_on), (32'(DT[i]) + 32'h8) >> 4);
    end
    $display("test idle_duty done");
    wr(ADDR_SUBF, 32'h2);
    start_frame(32'h9, 32'h80, 32'h102, 4);
    // New level must arrive after the frame has latched its own
    while (frame_active !== 1'b1) @(posedge aclk);
    wr(ADDR_DIM, 32'h20);
    rd(ADDR_STATUS);
    chk(32'(rdv[23:16]), 32'h80);
    chk(32'(rdv[0]), 32'h1);
    end_frame();
    chk(32'(frm_len_q), 32'd704);
    rng(32'(frm_on_q), 32'd383, 32'd385);
    repeat (40) @(posedge aclk);
    rd(ADDR_STATUS);
    chk(32'(rdv[23:16]), 32'h20);
    chk(32'(win_on), 32'h2);
    $display("test ook_subframes done");
    frame(32'h3, 32'h40, 32'h003, 2, 64, 304);
    frame(32'h3, 32'hff, 32'h103, 2, 304, 304);
    $display("test pulse_position done");
    frame(32'h7, 32'h80, 32'h0, 1, 64, 128);
    $display("test rolling_shutter done");
    frame(32'h5, 32'h90, 32'h0, 1, 0, 64);
    repeat (40) @(posedge aclk);
    chk(32'(amp_sum), 32'h90);
    $display("test colour_shift done");
    start_frame(32'h1, 32'h80, 32'h1ff, 1);
    end_frame();
    rng(32'(frm_len_q), 32'd224, 32'd256);
    rd(ADDR_STATUS);
    chk(32'(rdv[ST_FLICKER]), 32'h1);
    wr(ADDR_STATUS, 32'h10);
    rd(ADDR_STATUS);
    chk(32'(rdv[ST_FLICKER]), 32'h0);
    $display("test flicker_cap done");
    wr(ADDR_COMP, 32'h0);
    full = 1'b0;
    for (int i = 0; i < 60 && !full; i++) begin
      wr(ADDR_TXDATA, 32'h55);
      full = (wait_n > 8);
    end
    chk(32'(full), 32'h1);
    rd(ADDR_STATUS);
    chk(32'(rdv[10:5]), 32'd32);
    end_frame();
    rd(ADDR_STATUS);
    chk(32'(rdv[ST_UNDERRUN]), 32'h1);
    chk(32'(rdv[10:5]), 32'h0);
    wr(ADDR_STATUS, 32'h8);
    rd(ADDR_STATUS);
    chk(32'(rdv[ST_UNDERRUN]), 32'h0);
    $display("test fifo_underrun done");
    print_verdict();
  end
endmodule // otdfc_bench
`default_nettype wire

// >>> tb/otdfc_rx_model.sv
// Receiver model: photodetector light meter and colour power sum
`timescale 1ns/1ps
`default_nettype none
module otdfc_rx_model
  import otdfc_pkg::*;
(
  input wire logic aclk,
  input wire logic led_on,
  input wire otdfc_amp_t color_amp,
  input wire logic frame_active,
  input wire logic rx_clr,
  output logic [4:0] win_on,
  output logic [15:0] frm_on_q,
  output logic [15:0] frm_len_q,
  output logic [9:0] amp_sum
);
  logic [15:0] hist_q;
  // Light seen over the last 16 clocks and over each frame
  always_ff @(posedge aclk) begin
    hist_q <= {hist_q[14:0], led_on};
    if (rx_clr) begin
      frm_on_q <= '0;
      frm_len_q <= '0;
    end else if (frame_active) begin
      frm_on_q <= frm_on_q + 16'(led_on);
      frm_len_q <= frm_len_q + 16'h1;
    end
  end
  assign win_on = 5'($countones(hist_q));
  assign amp_sum = 10'(color_amp.src0) + 10'(color_amp.src1) + 10'(color_amp.src2);
endmodule // otdfc_rx_model
`default_nettype wire

// >>> verilog/otdfc_fifo.sv
// Show-ahead FIFO for coded transmit bytes
`timescale 1ns/1ps
`default_nettype none
module otdfc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("FIFO depth must be a power of two of at least 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d;
  logic push, pop;

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  assign level = wr_q - rd_q;
  assign in_ready = (level != DEPTH[AW:0]);
  assign out_valid = (wr_q != rd_q);
  assign out_data = mem[rd_q[AW-1:0]];
endmodule // otdfc_fifo
`default_nettype wire

// >>> verilog/otdfc_pkg.sv
// Package: constants and types for the optical dimming transmitter
package otdfc_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int CHIP_BITS = 4;
  localparam logic [4:0] CHIPS_PER_SYM = 5'h10;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DIM = 8'h04;
  localparam logic [7:0] ADDR_SUBF = 8'h08;
  localparam logic [7:0] ADDR_COMP = 8'h0c;
  localparam logic [7:0] ADDR_TXDATA = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_DIV = 8'h18;
  // Field positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_RESYNC = 3;
  localparam int COMP_POL = 8;
  localparam int TXD_LAST = 8;
  localparam int ST_BUSY = 0;
  localparam int ST_STATE_LSB = 1;
  localparam int ST_UNDERRUN = 3;
  localparam int ST_FLICKER = 4;
  localparam int ST_LEVEL_LSB = 5;
  localparam int ST_DIM_LSB = 16;
  // Reset values, resync length and bus response codes
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [7:0] DIM_RST = 8'h80;
  localparam logic [7:0] SUBF_RST = 8'h10;
  localparam logic [8:0] COMP_RST = 9'h000;
  localparam logic [15:0] DIV_RST = 16'h0018;
  localparam logic [7:0] RESYNC_SYMS = 8'h04;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    MODE_OOK = 2'b00,
    MODE_PULSE_POS = 2'b01,
    MODE_COLOR = 2'b10,
    MODE_ROLL_SHUT = 2'b11
  } otdfc_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_COMP = 2'b01,
    ST_RESYNC = 2'b10,
    ST_DATA = 2'b11
  } otdfc_state_t;

  typedef struct packed {
    logic last;
    logic [7:0] data;
  } otdfc_item_t;

  typedef struct packed {
    logic [7:0] src0;
    logic [7:0] src1;
    logic [7:0] src2;
  } otdfc_amp_t;
endpackage

// >>> verilog/otdfc_tick.sv
// Chip-rate divider and chip index within a symbol
`timescale 1ns/1ps
`default_nettype none
module otdfc_tick
  import otdfc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] div,
  output logic chip_en,
  output logic [CHIP_BITS-1:0] chip_idx,
  output logic sym_end
);
  logic [15:0] pre_q, pre_d;
  logic [CHIP_BITS-1:0] idx_q, idx_d;

  always_comb begin
    chip_en = (pre_q >= div);
    pre_d = chip_en ? 16'h0000 : pre_q + 16'h0001;
    idx_d = chip_en ? idx_q + 1'b1 : idx_q;
    sym_end = chip_en && (&idx_q);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= 16'h0000;
      idx_q <= '0;
    end else begin
      pre_q <= pre_d;
      idx_q <= idx_d;
    end
  end

  assign chip_idx = idx_q;
endmodule // otdfc_tick
`default_nettype wire

// >>> verilog/otdfc_top.sv
// Optical transmitter dimming and flicker control with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module otdfc_top
  import otdfc_pkg::*;
#(
  parameter int FIFO_DEPTH = 32,
  parameter int MAX_FLICKER_PERIOD_NS = 5000000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic led_on,
  output otdfc_amp_t color_amp,
  output logic frame_active
);
  localparam logic [31:0] FLICKER_CYC = 32'(MAX_FLICKER_PERIOD_NS / CLK_PERIOD_NS);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;
  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 64) begin : g_chk
    $error("FIFO depth must lie between 2 and 64");
  end

  function automatic logic [4:0] duty_chips(input logic [7:0] d);
    logic [8:0] s;
    s = {1'b0, d} + 9'h008;
    return s[8:4];
  endfunction

  function automatic logic manch(input logic b, input logic [CHIP_BITS-1:0] idx);
    return idx[CHIP_BITS-1] ? b : ~b;
  endfunction

  function automatic otdfc_amp_t color_point(input logic [1:0] s, input logic [7:0] d);
    otdfc_amp_t a;
    a = '0;
    case (s)
      2'b00: a.src0 = d;
      2'b01: a.src1 = d;
      2'b10: a.src2 = d;
      default: begin
        a.src0 = d - {1'b0, d[7:1]};
        a.src1 = {1'b0, d[7:1]};
      end
    endcase
    return a;
  endfunction

  function automatic otdfc_amp_t color_centre(input logic [7:0] d);
    otdfc_amp_t a;
    logic [15:0] p;
    p = d * 8'h55;
    a.src1 = p[15:8];
    a.src2 = p[15:8];
    a.src0 = d - {p[14:8], 1'b0};
    return a;
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Register and bus state
  logic awready_q, awready_d, wready_q, wready_d, aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d, wm;
  logic [3:0] wstrb_q, wstrb_d, ctrl_q, ctrl_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [7:0] dim_reg_q, dim_reg_d, subf_q, subf_d;
  logic [8:0] comp_q, comp_d;
  logic [15:0] div_q, div_d;
  logic go, fifo_push, clr_under, clr_flick;
  // Transmit state
  otdfc_state_t state_q, state_d;
  otdfc_mode_t mode_q, mode_d;
  logic [7:0] dim_q, dim_d, sh_q, sh_d, subcnt_q, subcnt_d, cnt_q, cnt_d;
  logic [2:0] bit_q, bit_d;
  logic last_q, last_d, under_q, under_d, flickf_q, flickf_d, led_q, led_d;
  logic active_q, active_d, pop, enter_sub, enter_res, enter_load, flick_hit;
  logic [31:0] flick_q, flick_d;
  logic [4:0] dc;
  otdfc_amp_t amp_q, amp_d;
  // Submodule wires
  logic fifo_in_ready, fifo_out_valid, chip_en, sym_end;
  otdfc_item_t fifo_out, fifo_in;
  logic [LW-1:0] fifo_level;
  logic [CHIP_BITS-1:0] chip_idx;

  always_comb begin
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    ctrl_d = ctrl_q;
    dim_reg_d = dim_reg_q;
    subf_d = subf_q;
    comp_d = comp_q;
    div_d = div_q;
    fifo_push = 1'b0;
    clr_under = 1'b0;
    clr_flick = 1'b0;
    wm = '0;
    if (s_axi_awvalid && awready_q) begin
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    // A data write waits while the FIFO is full
    go = aw_have_q && w_have_q && !bvalid_q && (awaddr_q != ADDR_TXDATA || fifo_in_ready);
    if (go) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      if (awaddr_q == ADDR_CTRL) begin
        wm = wmerge({28'h0, ctrl_q}, wdata_q, wstrb_q);
        ctrl_d = wm[3:0];
      end else if (awaddr_q == ADDR_DIM) begin
        wm = wmerge({24'h0, dim_reg_q}, wdata_q, wstrb_q);
        dim_reg_d = wm[7:0];
      end else if (awaddr_q == ADDR_SUBF) begin
        wm = wmerge({24'h0, subf_q}, wdata_q, wstrb_q);
        subf_d = wm[7:0];
      end else if (awaddr_q == ADDR_COMP) begin
        wm = wmerge({23'h0, comp_q}, wdata_q, wstrb_q);
        comp_d = wm[8:0];
      end else if (awaddr_q == ADDR_TXDATA) begin
        fifo_push = 1'b1;
      end else if (awaddr_q == ADDR_STATUS) begin
        clr_under = wstrb_q[0] && wdata_q[ST_UNDERRUN];
        clr_flick = wstrb_q[0] && wdata_q[ST_FLICKER];
      end else if (awaddr_q == ADDR_DIV) begin
        wm = wmerge({16'h0, div_q}, wdata_q, wstrb_q);
        div_d = wm[15:0];
      end else begin
        bresp_d = RESP_SLVERR;
      end
    end
    awready_d = !aw_have_d;
    wready_d = !w_have_d;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
    if (s_axi_arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = '0;
      if (s_axi_araddr == ADDR_CTRL) begin
        rdata_d[3:0] = ctrl_q;
      end else if (s_axi_araddr == ADDR_DIM) begin
        rdata_d[7:0] = dim_reg_q;
      end else if (s_axi_araddr == ADDR_SUBF) begin
        rdata_d[7:0] = subf_q;
      end else if (s_axi_araddr == ADDR_COMP) begin
        rdata_d[8:0] = comp_q;
      end else if (s_axi_araddr == ADDR_TXDATA) begin
        rdata_d = '0;
      end else if (s_axi_araddr == ADDR_STATUS) begin
        rdata_d[ST_BUSY] = active_q;
        rdata_d[ST_STATE_LSB +: 2] = state_q;
        rdata_d[ST_UNDERRUN] = under_q;
        rdata_d[ST_FLICKER] = flickf_q;
        rdata_d[ST_LEVEL_LSB +: LW] = fifo_level;
        rdata_d[ST_DIM_LSB +: 8] = dim_q;
      end else if (s_axi_araddr == ADDR_DIV) begin
        rdata_d[15:0] = div_q;
      end else begin
        rresp_d = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
      ctrl_q <= CTRL_RST;
      dim_reg_q <= DIM_RST;
      subf_q <= SUBF_RST;
      comp_q <= COMP_RST;
      div_q <= DIV_RST;
    end else begin
      awready_q <= awready_d;
      wready_q <= wready_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      ctrl_q <= ctrl_d;
      dim_reg_q <= dim_reg_d;
      subf_q <= subf_d;
      comp_q <= comp_d;
      div_q <= div_d;
    end
  end

  assign fifo_in = '{last: wdata_q[TXD_LAST], data: wdata_q[7:0]};

  otdfc_fifo #(.WIDTH($bits(otdfc_item_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out),
    .level(fifo_level)
  );

  otdfc_tick u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .div(div_q),
    .chip_en(chip_en),
    .chip_idx(chip_idx),
    .sym_end(sym_end)
  );

  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    dim_d = dim_q;
    sh_d = sh_q;
    bit_d = bit_q;
    last_d = last_q;
    subcnt_d = subcnt_q;
    cnt_d = cnt_q;
    pop = 1'b0;
    enter_sub = 1'b0;
    enter_res = 1'b0;
    enter_load = 1'b0;
    flick_hit = (flick_q >= FLICKER_CYC);
    // Hit holds until the symbol end that acts on it
    flick_d = (state_q != ST_COMP) ? 32'h0 : (flick_hit ? flick_q : flick_q + 32'h1);
    under_d = under_q && !clr_under;
    flickf_d = flickf_q && !clr_flick;
    if (sym_end) begin
      case (state_q)
        ST_IDLE: begin
          dim_d = dim_reg_q;
          mode_d = otdfc_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
          if (ctrl_q[CTRL_EN] && fifo_out_valid) begin
            subcnt_d = 8'h00;
            enter_sub = 1'b1;
          end
        end
        ST_COMP: begin
          if (flick_hit) begin
            flickf_d = 1'b1;
            enter_res = 1'b1;
          end else if (cnt_q == 8'h00) begin
            enter_res = 1'b1;
          end else begin
            cnt_d = cnt_q - 8'h01;
          end
        end
        ST_RESYNC: begin
          if (cnt_q == 8'h00) begin
            enter_load = 1'b1;
          end else begin
            cnt_d = cnt_q - 8'h01;
          end
        end
        ST_DATA: begin
          if (bit_q != 3'h0) begin
            bit_d = bit_q - 3'h1;
            sh_d = (mode_q == MODE_COLOR) ? {sh_q[5:0], 2'b00} : {sh_q[6:0], 1'b0};
          end else if (last_q) begin
            state_d = ST_IDLE;
          end else if (mode_q == MODE_OOK && subf_q != 8'h00 && subcnt_q == subf_q - 8'h01) begin
            subcnt_d = 8'h00;
            enter_sub = 1'b1;
          end else begin
            subcnt_d = subcnt_q + 8'h01;
            enter_load = 1'b1;
          end
        end
        default: state_d = ST_IDLE;
      endcase
    end
    if (enter_sub) begin
      if (comp_q[7:0] != 8'h00) begin
        state_d = ST_COMP;
        cnt_d = comp_q[7:0] - 8'h01;
      end else begin
        enter_res = 1'b1;
      end
    end
    if (enter_res) begin
      if (mode_d == MODE_OOK && ctrl_q[CTRL_RESYNC]) begin
        state_d = ST_RESYNC;
        cnt_d = RESYNC_SYMS - 8'h01;
      end else begin
        enter_load = 1'b1;
      end
    end
    if (enter_load) begin
      if (fifo_out_valid) begin
        pop = 1'b1;
        sh_d = fifo_out.data;
        last_d = fifo_out.last;
        bit_d = (mode_d == MODE_COLOR) ? 3'h3 : 3'h7;
        state_d = ST_DATA;
      end else begin
        under_d = 1'b1;
        state_d = ST_IDLE;
      end
    end
    active_d = (state_d != ST_IDLE);
    // Light level for the current chip
    dc = duty_chips(dim_q);
    led_d = led_q;
    amp_d = amp_q;
    if (chip_en) begin
      amp_d = '0;
      case (state_q)
        ST_COMP: led_d = comp_q[COMP_POL];
        ST_RESYNC: led_d = manch(cnt_q[0], chip_idx);
        ST_DATA: begin
          case (mode_q)
            MODE_OOK: led_d = manch(sh_q[7], chip_idx);
            MODE_PULSE_POS: led_d = sh_q[7] ? ({1'b0, chip_idx} >= CHIPS_PER_SYM - dc)
                                       : ({1'b0, chip_idx} < dc);
            MODE_COLOR: begin
              led_d = 1'b0;
              amp_d = color_point(sh_q[7:6], dim_q);
            end
            default: led_d = sh_q[7] ? ({1'b0, chip_idx[CHIP_BITS-2:0], 1'b0} < dc)
                                     : ({1'b0, chip_idx} < dc);
          endcase
        end
        default: begin
          led_d = (mode_q != MODE_COLOR) && ({1'b0, chip_idx} < dc);
          if (mode_q == MODE_COLOR) begin
            amp_d = color_centre(dim_q);
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      mode_q <= MODE_OOK;
      dim_q <= DIM_RST;
      sh_q <= 8'h00;
      bit_q <= 3'h0;
      last_q <= 1'b0;
      subcnt_q <= 8'h00;
      cnt_q <= 8'h00;
      flick_q <= 32'h0;
      under_q <= 1'b0;
      flickf_q <= 1'b0;
      led_q <= 1'b0;
      amp_q <= '0;
      active_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      dim_q <= dim_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      last_q <= last_d;
      subcnt_q <= subcnt_d;
      cnt_q <= cnt_d;
      flick_q <= flick_d;
      under_q <= under_d;
      flickf_q <= flickf_d;
      led_q <= led_d;
      amp_q <= amp_d;
      active_q <= active_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign led_on = led_q;
  assign color_amp = amp_q;
  assign frame_active = active_q;
endmodule // otdfc_top
`default_nettype wire
